// ### tie_timer_irq.sv
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ns
// Behaviour
// R01: Capture registers clear on reset or standby
// R02: Capture copies counter even if flag set
// R03: Eight-bit enable register, software read/write
// R04: Enable register resets to one
// R05: Bit 7 gates capture A request
// R06: Bit 6 gates capture B request
// R07: Bit 5 gates capture C request
// R08: Bit 4 gates capture D request
// R09: Bit 3 gates compare A request
// R10: Bit 2 gates compare B request
// R11: Bit 1 gates overflow request
// R12: Bit 0 ignores writes, reads one
// R13: Overflow flag sets on counter wrap
// R14: Flags cleared by read-one then write-zero
// R15: Compare flags set on counter match
// R16: Buffered mode makes C a pure edge flag
// R17: Request is flag AND enable
module tie_timer_irq
  import tie_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // Clock, reset and standby
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic standby_in,
  // Capture pins, asynchronous
  input wire logic [3:0] capture_pin_in,
  // AXI4-Lite write
  input wire logic [15:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  // AXI4-Lite read
  input wire logic [15:0] araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in,
  // Interrupt requests
  output logic capture_a_irq,
  output logic capture_b_irq,
  output logic capture_c_irq,
  output logic capture_d_irq,
  output logic compare_a_irq,
  output logic compare_b_irq,
  output logic counter_overflow_irq,
  output logic irq_out
);
  logic wr_stb; // Write strobe from bus slave
  tie_wreq_s wr_req; // Write address, data, strobes
  logic wr_ok; // Write address mapped
  logic rd_stb; // Read strobe
  logic [15:0] rd_addr; // Read address
  logic [31:0] rd_data; // Read data to slave
  logic rd_ok; // Read address mapped
  logic [3:0] pin_sync; // Synchronised capture pins
  logic [3:0] pin_prev; // Previous synchronised level
  logic [3:0] cap_evt; // Rising-edge capture events
  logic [7:0] timer_irq_enable; // Enable register
  logic [7:0] timer_flag_status; // Sticky flags, bit 0 is counter clear select
  logic [7:0] flags_seen; // Flags read as one since last clear
  logic [7:0] ctrl; // Buffer control; counter clear is selected by status bit 0
  logic [7:0] irq_mask; // Mask for the summary output
  logic [CNT_W-1:0] free_running_counter; // Counter
  logic [CNT_W-1:0] compare_reg_a; // Compare A
  logic [CNT_W-1:0] compare_reg_b; // Compare B
  logic [CNT_W-1:0] cap_reg [4]; // Capture registers A to D
  logic [7:0] flag_set; // Hardware set events
  logic [7:0] flag_clr; // Software clear events
  logic capture_buffer_a_en; // Channel C buffers channel A
  logic wr_lo; // Low byte lane written
  logic wr_word; // Low two lanes written
  logic soft_init; // Reset-like standby reinit

  assign soft_init = standby_in;
  assign capture_buffer_a_en = ctrl[TIE_CTRL_BUF_A];
  assign wr_lo = wr_stb && wr_req.strb[0];
  assign wr_word = wr_stb && (wr_req.strb[1:0] == 2'h3);

  // Bus slave
  tie_axil u_axil (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .awaddr_in(awaddr_in),
    .awvalid_in(awvalid_in),
    .awready_out(awready_out),
    .wdata_in(wdata_in),
    .wstrb_in(wstrb_in),
    .wvalid_in(wvalid_in),
    .wready_out(wready_out),
    .bresp_out(bresp_out),
    .bvalid_out(bvalid_out),
    .bready_in(bready_in),
    .araddr_in(araddr_in),
    .arvalid_in(arvalid_in),
    .arready_out(arready_out),
    .rdata_out(rdata_out),
    .rresp_out(rresp_out),
    .rvalid_out(rvalid_out),
    .rready_in(rready_in),
    .wr_stb_out(wr_stb),
    .wr_req_out(wr_req),
    .wr_ok_in(wr_ok),
    .rd_stb_out(rd_stb),
    .rd_addr_out(rd_addr),
    .rd_data_in(rd_data),
    .rd_ok_in(rd_ok)
  );

  // Capture pin synchroniser
  tie_sync #(.WIDTH(4)) u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .async_in(capture_pin_in),
    .sync_out(pin_sync)
  );

  // Edge detect on synchronised pins, rising edge
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      pin_prev <= '0;
    end else begin
      pin_prev <= pin_sync;
    end
  end
  assign cap_evt = pin_sync & ~pin_prev;

  // Free-running counter with optional clear on compare A
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      free_running_counter <= '0;
    end else if (soft_init) begin
      free_running_counter <= '0;
    end else if (wr_word && wr_req.addr == TIE_ADDR_CTRL + 16'h0002) begin
      free_running_counter <= wr_req.data[CNT_W-1:0];
    end else if (timer_flag_status[TIE_BIT_RSVD] && free_running_counter == compare_reg_a) begin
      free_running_counter <= '0;
    end else begin
      free_running_counter <= free_running_counter + 1'b1;
    end
  end

  // Compare registers
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      compare_reg_a <= TIE_CMP_RST;
      compare_reg_b <= TIE_CMP_RST;
    end else if (soft_init) begin
      compare_reg_a <= TIE_CMP_RST;
      compare_reg_b <= TIE_CMP_RST;
    end else if (wr_word && wr_req.addr == TIE_ADDR_CMP_A) begin
      compare_reg_a <= wr_req.data[CNT_W-1:0];
    end else if (wr_word && wr_req.addr == TIE_ADDR_CMP_B) begin
      compare_reg_b <= wr_req.data[CNT_W-1:0];
    end
  end

  // Capture registers, one per channel
  for (genvar g = 0; g < 4; g++) begin : g_cap
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
        cap_reg[g] <= TIE_CAP_RST; // [R01]
      end else if (soft_init) begin
        cap_reg[g] <= TIE_CAP_RST; // [R01]
      end else if (g == 2 && capture_buffer_a_en) begin
        // Channel C holds old A value, its own pin captures nothing
        if (cap_evt[0]) begin
          cap_reg[g] <= cap_reg[0]; // [R16]
        end
      end else if (cap_evt[g]) begin
        cap_reg[g] <= free_running_counter; // Flag state ignored [R02]
      end
    end
  end

  // Hardware set events in status bit order
  always_comb begin
    flag_set = '0;
    flag_set[TIE_BIT_CAP_A] = cap_evt[0];
    flag_set[TIE_BIT_CAP_B] = cap_evt[1];
    flag_set[TIE_BIT_CAP_C] = cap_evt[2]; // Edge flag in buffered mode too [R16]
    flag_set[TIE_BIT_CAP_D] = cap_evt[3];
    flag_set[TIE_BIT_CMP_A] = (free_running_counter == compare_reg_a); // [R15]
    flag_set[TIE_BIT_CMP_B] = (free_running_counter == compare_reg_b); // [R15]
    flag_set[TIE_BIT_OVF] = (free_running_counter == TIE_CNT_MAX); // Wrap next edge [R13]
  end

  // Clear only flags previously read as one and now written zero
  always_comb begin
    flag_clr = '0;
    if (wr_lo && wr_req.addr == TIE_ADDR_STATUS) begin
      flag_clr = flags_seen & ~wr_req.data[7:0]; // [R14]
    end
    flag_clr[TIE_BIT_RSVD] = 1'b0;
  end

  // Status flags: set wins over clear, software sets only bit 0
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      timer_flag_status <= TIE_STATUS_RST;
    end else if (soft_init) begin
      timer_flag_status <= TIE_STATUS_RST;
    end else begin
      timer_flag_status[7:1] <= flag_set[7:1] | (timer_flag_status[7:1] & ~flag_clr[7:1]); // [R14]
      if (wr_lo && wr_req.addr == TIE_ADDR_STATUS) begin
        timer_flag_status[TIE_BIT_RSVD] <= wr_req.data[TIE_BIT_RSVD];
      end
    end
  end

  // Remember flags seen as one by a status read
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      flags_seen <= '0;
    end else if (soft_init) begin
      flags_seen <= '0;
    end else if (rd_stb && rd_addr == TIE_ADDR_STATUS) begin
      flags_seen <= timer_flag_status & 8'hFE; // [R14]
    end else begin
      flags_seen <= flags_seen & ~flag_clr;
    end
  end

  // Enable register, bit 0 fixed at one
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      timer_irq_enable <= TIE_ENABLE_RST; // [R04]
    end else if (soft_init) begin
      timer_irq_enable <= TIE_ENABLE_RST; // [R04]
    end else if (wr_lo && wr_req.addr == TIE_ADDR_ENABLE) begin
      timer_irq_enable <= {wr_req.data[7:1], 1'b1}; // [R03] [R12]
    end
  end

  // Control and mask registers
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl <= '0;
      irq_mask <= '0;
    end else if (soft_init) begin
      ctrl <= '0;
      irq_mask <= '0;
    end else if (wr_lo && wr_req.addr == TIE_ADDR_CTRL) begin
      ctrl <= wr_req.data[7:0];
    end else if (wr_lo && wr_req.addr == TIE_ADDR_IRQ_MASK) begin
      irq_mask <= {wr_req.data[7:1], 1'b0};
    end
  end

  // Write address decode
  always_comb begin
    unique case (wr_req.addr)
      TIE_ADDR_ENABLE, TIE_ADDR_STATUS, TIE_ADDR_CTRL, TIE_ADDR_CMP_A,
      TIE_ADDR_CMP_B, TIE_ADDR_IRQ_MASK, TIE_ADDR_CTRL + 16'h0002: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // Read mux
  always_comb begin
    rd_data = '0;
    rd_ok = 1'b1;
    unique case (rd_addr)
      TIE_ADDR_ENABLE: rd_data[7:0] = timer_irq_enable | 8'h01; // [R03] [R12]
      TIE_ADDR_STATUS: rd_data[7:0] = timer_flag_status;
      TIE_ADDR_CTRL: rd_data[7:0] = ctrl;
      TIE_ADDR_CMP_A: rd_data[15:0] = compare_reg_a;
      TIE_ADDR_CMP_B: rd_data[15:0] = compare_reg_b;
      TIE_ADDR_CAP_A: rd_data[15:0] = cap_reg[0];
      TIE_ADDR_CAP_B: rd_data[15:0] = cap_reg[1];
      TIE_ADDR_CAP_C: rd_data[15:0] = cap_reg[2];
      TIE_ADDR_CAP_D: rd_data[15:0] = cap_reg[3];
      TIE_ADDR_IRQ_MASK: rd_data[7:0] = irq_mask;
      default: rd_ok = 1'b0;
    endcase
  end

  // Request lines: flag AND enable, summary is flag AND mask, registered
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      capture_a_irq <= 1'b0;
      capture_b_irq <= 1'b0;
      capture_c_irq <= 1'b0;
      capture_d_irq <= 1'b0;
      compare_a_irq <= 1'b0;
      compare_b_irq <= 1'b0;
      counter_overflow_irq <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      capture_a_irq <= timer_flag_status[TIE_BIT_CAP_A] & timer_irq_enable[TIE_BIT_CAP_A]; // [R05] [R17]
      capture_b_irq <= timer_flag_status[TIE_BIT_CAP_B] & timer_irq_enable[TIE_BIT_CAP_B]; // [R06] [R17]
      capture_c_irq <= timer_flag_status[TIE_BIT_CAP_C] & timer_irq_enable[TIE_BIT_CAP_C]; // [R07] [R17]
      capture_d_irq <= timer_flag_status[TIE_BIT_CAP_D] & timer_irq_enable[TIE_BIT_CAP_D]; // [R08] [R17]
      compare_a_irq <= timer_flag_status[TIE_BIT_CMP_A] & timer_irq_enable[TIE_BIT_CMP_A]; // [R09] [R17]
      compare_b_irq <= timer_flag_status[TIE_BIT_CMP_B] & timer_irq_enable[TIE_BIT_CMP_B]; // [R10] [R17]
      counter_overflow_irq <= timer_flag_status[TIE_BIT_OVF] & timer_irq_enable[TIE_BIT_OVF]; // [R11] [R17]
      irq_out <= |(timer_flag_status[7:1] & irq_mask[7:1]);
    end
  end
endmodule // tie_timer_irq

// ### tie_pkg.sv
package tie_pkg;
  // Register byte addresses on the AXI4-Lite slave
  localparam logic [15:0] TIE_ADDR_ENABLE = 16'hFF90;
  localparam logic [15:0] TIE_ADDR_STATUS = 16'hFF91;
  localparam logic [15:0] TIE_ADDR_CTRL = 16'hFF96;
  localparam logic [15:0] TIE_ADDR_CAP_A = 16'hFF98;
  localparam logic [15:0] TIE_ADDR_CAP_B = 16'hFF9A;
  localparam logic [15:0] TIE_ADDR_CAP_C = 16'hFF9C;
  localparam logic [15:0] TIE_ADDR_CAP_D = 16'hFF9E;
  localparam logic [15:0] TIE_ADDR_CMP_A = 16'hFF94;
  localparam logic [15:0] TIE_ADDR_CMP_B = 16'hFFA0;
  localparam logic [15:0] TIE_ADDR_IRQ_MASK = 16'hFFA4;
  // Reset values and counter maximum
  localparam logic [7:0] TIE_ENABLE_RST = 8'h01;
  localparam logic [7:0] TIE_STATUS_RST = 8'h00;
  localparam logic [15:0] TIE_CAP_RST = 16'h0000;
  localparam logic [15:0] TIE_CMP_RST = 16'hFFFF;
  localparam logic [15:0] TIE_CNT_MAX = 16'hFFFF;
  // Field positions shared by the enable and status registers
  localparam int TIE_BIT_CAP_A = 7;
  localparam int TIE_BIT_CAP_B = 6;
  localparam int TIE_BIT_CAP_C = 5;
  localparam int TIE_BIT_CAP_D = 4;
  localparam int TIE_BIT_CMP_A = 3;
  localparam int TIE_BIT_CMP_B = 2;
  localparam int TIE_BIT_OVF = 1;
  localparam int TIE_BIT_RSVD = 0;
  // Control register fields
  localparam int TIE_CTRL_BUF_A = 0;
  localparam int TIE_CTRL_CCLR = 1;
  // AXI response codes
  localparam logic [1:0] TIE_RESP_OK = 2'h0;
  localparam logic [1:0] TIE_RESP_ERR = 2'h2;
  // Write request carried from the bus slave
  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } tie_wreq_s;
endpackage

// ### tie_sync.sv
`timescale 1ns/1ns
// Two-stage synchroniser for the capture pins
module tie_sync
  import tie_pkg::*;
#(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1; // Only read by the second stage

  // Two flops per bit
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule // tie_sync

// ### tie_axil.sv
`timescale 1ns/1ns
// AXI4-Lite slave: accepts one write and one read at a time
module tie_axil
  import tie_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // AXI write channels
  input wire logic [15:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  // AXI read channels
  input wire logic [15:0] araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in,
  // Register core side
  output logic wr_stb_out,
  output tie_wreq_s wr_req_out,
  input wire logic wr_ok_in,
  output logic rd_stb_out,
  output logic [15:0] rd_addr_out,
  input wire logic [31:0] rd_data_in,
  input wire logic rd_ok_in
);
  logic aw_held; // Address taken
  logic w_held; // Data taken
  logic rd_wait; // Read strobe issued, data next cycle

  // Write address and data, in either order
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awready_out <= 1'b1;
      wready_out <= 1'b1;
      wr_req_out <= '0;
      wr_stb_out <= 1'b0;
    end else begin
      wr_stb_out <= 1'b0;
      if (awvalid_in && awready_out) begin
        wr_req_out.addr <= awaddr_in;
        aw_held <= 1'b1;
        awready_out <= 1'b0;
      end
      if (wvalid_in && wready_out) begin
        wr_req_out.data <= wdata_in;
        wr_req_out.strb <= wstrb_in;
        w_held <= 1'b1;
        wready_out <= 1'b0;
      end
      // Both halves present: one strobe to the core
      if (aw_held && w_held && !bvalid_out && !wr_stb_out) begin
        wr_stb_out <= 1'b1;
      end
      // Response taken: reopen both channels
      if (bvalid_out && bready_in) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        awready_out <= 1'b1;
        wready_out <= 1'b1;
      end
    end
  end

  // Write response
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      bvalid_out <= 1'b0;
      bresp_out <= TIE_RESP_OK;
    end else if (wr_stb_out) begin
      bvalid_out <= 1'b1;
      bresp_out <= wr_ok_in ? TIE_RESP_OK : TIE_RESP_ERR;
    end else if (bvalid_out && bready_in) begin
      bvalid_out <= 1'b0;
    end
  end

  // Read path: strobe the core, then present data
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      arready_out <= 1'b1;
      rd_stb_out <= 1'b0;
      rd_addr_out <= '0;
      rd_wait <= 1'b0;
      rvalid_out <= 1'b0;
      rdata_out <= '0;
      rresp_out <= TIE_RESP_OK;
    end else begin
      rd_stb_out <= 1'b0;
      rd_wait <= rd_stb_out;
      if (arvalid_in && arready_out) begin
        rd_addr_out <= araddr_in;
        rd_stb_out <= 1'b1;
        arready_out <= 1'b0;
      end
      if (rd_wait) begin
        rvalid_out <= 1'b1;
        rdata_out <= rd_data_in;
        rresp_out <= rd_ok_in ? TIE_RESP_OK : TIE_RESP_ERR;
      end else if (rvalid_out && rready_in) begin
        rvalid_out <= 1'b0;
        arready_out <= 1'b1;
      end
    end
  end
endmodule // tie_axil

// ### tie_timer_irq_sva.sv
`timescale 1ns/1ns
// Port-level checks of gating and enable reads
module tie_timer_irq_sva
  import tie_pkg::*;
(
  // Clock, reset and standby
  input wire logic clk_sys_in, rst_in, standby_in,
  // Bus
  input wire logic [15:0] awaddr_in,
  input wire logic awvalid_in, awready_out, wvalid_in, wready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic [15:0] araddr_in,
  input wire logic arvalid_in, arready_out, rvalid_out, rready_in,
  input wire logic [31:0] rdata_out,
  input wire logic [1:0] rresp_out,
  // Requests
  input wire logic capture_a_irq, capture_b_irq, capture_c_irq, capture_d_irq,
  input wire logic compare_a_irq, compare_b_irq, counter_overflow_irq, irq_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // Request lines in enable bit order
  wire logic [7:1] irqs = {capture_a_irq, capture_b_irq, capture_c_irq, capture_d_irq,
                           compare_a_irq, compare_b_irq, counter_overflow_irq};
  logic en_wr; // Write to the enable register taken last cycle
  logic [7:1] en_clr; // Enable bits just written to zero
  logic [7:1] en_last; // Enable bits last written
  logic rd_en; // Read in flight targets the enable register
  wire logic en_hs = awvalid_in && awready_out && wvalid_in && wready_out && awaddr_in == TIE_ADDR_ENABLE && wstrb_in[0];
  // Track enable writes and reads
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      en_wr <= 1'b0;
      en_clr <= 7'h00;
      en_last <= 7'h00;
      rd_en <= 1'b0;
    end else begin
      en_wr <= en_hs;
      en_clr <= en_wr ? ~en_last : 7'h00;
      if (standby_in) begin
        en_last <= 7'h00;
      end else if (en_hs) begin
        en_last <= wdata_in[7:1];
      end
      if (arvalid_in && arready_out) begin
        rd_en <= araddr_in == TIE_ADDR_ENABLE;
      end
    end
  end
  property p_rst_idle; $fell(rst_in) |-> irqs == 7'h00; endproperty
  property p_standby; standby_in |-> ##2 irqs == 7'h00; endproperty
  property p_rsvd; rvalid_out && rready_in && rd_en |-> rdata_out[0]; endproperty
  property p_en_rw; rvalid_out && rready_in && rd_en && !standby_in |-> rdata_out[7:1] == en_last; endproperty
  property p_cap_a; en_clr[7] |-> ##[0:5] !capture_a_irq; endproperty
  property p_cap_b; en_clr[6] |-> ##[0:5] !capture_b_irq; endproperty
  property p_cap_c; en_clr[5] |-> ##[0:5] !capture_c_irq; endproperty
  property p_cap_d; en_clr[4] |-> ##[0:5] !capture_d_irq; endproperty
  property p_cmp_a; en_clr[3] |-> ##[0:5] !compare_a_irq; endproperty
  property p_cmp_b; en_clr[2] |-> ##[0:5] !compare_b_irq; endproperty
  property p_ovf; en_clr[1] |-> ##[0:5] !counter_overflow_irq; endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("request after reset");
  a_standby: assert property (p_standby) else $error("request after standby");
  a_rsvd: assert property (p_rsvd) else $error("reserved bit low");
  a_en_rw: assert property (p_en_rw) else $error("enable readback differs");
  a_cap_a: assert property (p_cap_a) else $error("capture a not gated");
  a_cap_b: assert property (p_cap_b) else $error("capture b not gated");
  a_cap_c: assert property (p_cap_c) else $error("capture c not gated");
  a_cap_d: assert property (p_cap_d) else $error("capture d not gated");
  a_cmp_a: assert property (p_cmp_a) else $error("compare a not gated");
  a_cmp_b: assert property (p_cmp_b) else $error("compare b not gated");
  a_ovf: assert property (p_ovf) else $error("overflow not gated");
  // Main scenarios reached
  c_ovf: cover property (counter_overflow_irq);
  c_irq: cover property (irq_out);
  c_err: cover property (rvalid_out && rresp_out == TIE_RESP_ERR);
  c_stby: cover property (standby_in);
endmodule // tie_timer_irq_sva

// ### tie_cpu_model.sv
`timescale 1ns/1ns
// Processor bus master
module tie_cpu_model
  import tie_pkg::*;
(
  input wire logic clk_in,
  output logic [15:0] awaddr_out, araddr_out,
  output logic [31:0] wdata_out,
  output logic [3:0] wstrb_out,
  output logic awvalid_out, wvalid_out, bready_out, arvalid_out, rready_out,
  input wire logic awready_in, wready_in, bvalid_in, arready_in, rvalid_in,
  input wire logic [1:0] bresp_in, rresp_in,
  input wire logic [31:0] rdata_in
);
  // Idle bus at time zero
  initial begin
    {awaddr_out, awvalid_out, wdata_out, wstrb_out, wvalid_out, bready_out} = '0;
    {araddr_out, arvalid_out, rready_out} = '0;
  end
  // Offer address and data, drop each once taken
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_in);
    awaddr_out <= a;
    wdata_out <= d;
    wstrb_out <= s;
    awvalid_out <= 1'b1;
    wvalid_out <= 1'b1;
    bready_out <= 1'b1;
    do begin
      @(posedge clk_in);
      if (awready_in) awvalid_out <= 1'b0;
      if (wready_in) wvalid_out <= 1'b0;
    end while (!bvalid_in);
    bready_out <= 1'b0;
  endtask
  // Read: take data and response with rvalid
  task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_in);
    araddr_out <= a;
    arvalid_out <= 1'b1;
    rready_out <= 1'b1;
    do begin
      @(posedge clk_in);
      if (arready_in) arvalid_out <= 1'b0;
    end while (!rvalid_in);
    d = rdata_in;
    r = rresp_in;
    rready_out <= 1'b0;
  endtask
endmodule // tie_cpu_model

// ### tb.sv
`timescale 1ns/1ns
// Self-checking bench for the timer interrupt block
module tb
  import tie_pkg::*;
;
  // Expected read result
  typedef struct {string n; logic [31:0] x; logic [31:0] m; logic [1:0] r;} tie_exp_s;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic standby_in = 1'b0;
  logic [3:0] capture_pin_in = 4'h0;
  logic [15:0] awaddr_in, araddr_in;
  logic [31:0] wdata_in, rdata_out, v, rnd;
  logic [3:0] wstrb_in;
  logic [1:0] bresp_out, rresp_out, rs;
  logic awvalid_in, awready_out, wvalid_in, wready_out, bvalid_out, bready_in;
  logic arvalid_in, arready_out, rvalid_out, rready_in;
  logic capture_a_irq, capture_b_irq, capture_c_irq, capture_d_irq;
  logic compare_a_irq, compare_b_irq, counter_overflow_irq, irq_out;
  wire logic [7:0] irqs = {capture_a_irq, capture_b_irq, capture_c_irq, capture_d_irq,
                           compare_a_irq, compare_b_irq, counter_overflow_irq, irq_out};
  tie_exp_s exp_q[$]; // Pending read expectations
  tie_exp_s e; // Expectation under comparison
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0; // Run length guard
  logic [15:0] caps [4] = '{TIE_ADDR_CAP_A, TIE_ADDR_CAP_B, TIE_ADDR_CAP_C, TIE_ADDR_CAP_D};
  always #5 clk_sys_in = ~clk_sys_in;
  tie_timer_irq dut_u (.clk_sys_in, .rst_in, .standby_in, .capture_pin_in, .awaddr_in, .awvalid_in,
    .awready_out, .wdata_in, .wstrb_in, .wvalid_in, .wready_out, .bresp_out, .bvalid_out, .bready_in,
    .araddr_in, .arvalid_in, .arready_out, .rdata_out, .rresp_out, .rvalid_out, .rready_in,
    .capture_a_irq, .capture_b_irq, .capture_c_irq, .capture_d_irq, .compare_a_irq, .compare_b_irq,
    .counter_overflow_irq, .irq_out);
  tie_cpu_model cpu_u (.clk_in(clk_sys_in), .awaddr_out(awaddr_in), .awvalid_out(awvalid_in),
    .awready_in(awready_out), .wdata_out(wdata_in), .wstrb_out(wstrb_in), .wvalid_out(wvalid_in),
    .wready_in(wready_out), .bresp_in(bresp_out), .bvalid_in(bvalid_out), .bready_out(bready_in),
    .araddr_out(araddr_in), .arvalid_out(arvalid_in), .arready_in(arready_out), .rdata_in(rdata_out),
    .rresp_in(rresp_out), .rvalid_in(rvalid_out), .rready_out(rready_in));
  // Print counts and verdict, then stop
  task automatic close_out();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Cut a hang short
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      close_out();
    end
  end
  // Check reads against oldest expectation
  always @(posedge clk_sys_in) begin
    if (rvalid_out === 1'b1 && rready_in && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      checks_done++;
      if ((rdata_out & e.m) !== (e.x & e.m) || rresp_out !== e.r) begin
        miscompares++;
        $display("unexpected %s expected %h/%h seen %h/%h", e.n, e.x & e.m, e.r, rdata_out & e.m, rresp_out);
      end
    end
  end
  // Note an expectation, then read
  task automatic rd_chk(input string n, input logic [15:0] a, input logic [31:0] x, input logic [31:0] m,
                        input logic [1:0] r);
    exp_q.push_back('{n, x, m, r});
    cpu_u.rd(a, v, rs);
  endtask
  // Check requests after settling
  task automatic chk(input string n, input logic [7:0] x);
    repeat (3) @(posedge clk_sys_in);
    checks_done++;
    if (irqs !== x) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, x, irqs);
    end
  endtask
  // Raise chosen pins for three cycles
  task automatic pulse(input logic [3:0] p);
    capture_pin_in <= p;
    repeat (3) @(posedge clk_sys_in);
    capture_pin_in <= 4'h0;
  endtask
  // Main sequence
  initial begin
    rnd = $urandom(32'hC50E);
    repeat (8) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    rd_chk("enable", TIE_ADDR_ENABLE, 32'h01, 32'hFF, TIE_RESP_OK);
    rd_chk("status", TIE_ADDR_STATUS, 32'h00, 32'hFF, TIE_RESP_OK);
    foreach (caps[i]) rd_chk("capture", caps[i], 32'h0, 32'hFFFF, TIE_RESP_OK);
    rd_chk("unmapped", 16'hFFB0, 32'h0, 32'h0, TIE_RESP_ERR);
    $display("test reset done");
    rnd = $urandom;
    cpu_u.wr(TIE_ADDR_ENABLE, {24'h0, rnd[7:1], 1'b0}, 4'h1);
    rd_chk("enable", TIE_ADDR_ENABLE, {24'h0, rnd[7:1], 1'b1}, 32'hFF, TIE_RESP_OK);
    cpu_u.wr(TIE_ADDR_ENABLE, 32'h0, 4'h1);
    cpu_u.wr(TIE_ADDR_IRQ_MASK, 32'h0, 4'h1);
    cpu_u.wr(TIE_ADDR_CMP_A, 32'hFFF4, 4'h3);
    cpu_u.wr(TIE_ADDR_CMP_B, 32'hFFF8, 4'h3);
    cpu_u.wr(TIE_ADDR_CAP_A, 32'hFFF0, 4'h3);
    pulse(4'hF);
    repeat (47) @(posedge clk_sys_in);
    pulse(4'h1);
    repeat (40) @(posedge clk_sys_in);
    chk("disabled", 8'h00);
    rd_chk("status", TIE_ADDR_STATUS, 32'hFE, 32'hFF, TIE_RESP_OK);
    rd_chk("capture b", TIE_ADDR_CAP_B, 32'h0, 32'h0, TIE_RESP_OK);
    rd_chk("capture a", TIE_ADDR_CAP_A, v + 32'h32, 32'hFFFF, TIE_RESP_OK);
    $display("test flags done");
    for (int k = 7; k >= 1; k--) begin
      cpu_u.wr(TIE_ADDR_ENABLE, 32'h1 << k, 4'h1);
      chk("request", 8'h1 << k);
    end
    cpu_u.wr(TIE_ADDR_ENABLE, 32'hFE, 4'h1);
    cpu_u.wr(TIE_ADDR_IRQ_MASK, 32'hFE, 4'h1);
    chk("all", 8'hFF);
    cpu_u.wr(TIE_ADDR_STATUS, 32'hFE, 4'h1);
    rd_chk("status", TIE_ADDR_STATUS, 32'hFE, 32'hFF, TIE_RESP_OK);
    cpu_u.wr(TIE_ADDR_STATUS, 32'h00, 4'h1);
    chk("cleared", 8'h00);
    rd_chk("status", TIE_ADDR_STATUS, 32'h00, 32'hFF, TIE_RESP_OK);
    $display("test gating done");
    pulse(4'hF);
    chk("captures", 8'hF1);
    standby_in <= 1'b1;
    @(posedge clk_sys_in);
    standby_in <= 1'b0;
    chk("standby", 8'h00);
    rd_chk("enable", TIE_ADDR_ENABLE, 32'h01, 32'hFF, TIE_RESP_OK);
    foreach (caps[i]) rd_chk("capture", caps[i], 32'h0, 32'hFFFF, TIE_RESP_OK);
    cpu_u.wr(TIE_ADDR_CTRL, 32'h1, 4'h1);
    pulse(4'h1);
    rd_chk("capture a", TIE_ADDR_CAP_A, 32'h0, 32'h0, TIE_RESP_OK);
    pulse(4'h5);
    rd_chk("capture c", TIE_ADDR_CAP_C, v, 32'hFFFF, TIE_RESP_OK);
    $display("test standby done");
    repeat (4) @(posedge clk_sys_in);
    close_out();
  end
endmodule // tb
bind tie_timer_irq tie_timer_irq_sva chk_u (.clk_sys_in, .rst_in, .standby_in, .awaddr_in, .awvalid_in,
  .awready_out, .wdata_in, .wstrb_in, .wvalid_in, .wready_out, .araddr_in, .arvalid_in, .arready_out,
  .rdata_out, .rresp_out, .rvalid_out, .rready_in, .capture_a_irq, .capture_b_irq, .capture_c_irq,
  .capture_d_irq, .compare_a_irq, .compare_b_irq, .counter_overflow_irq, .irq_out);
